// ### skf_axis.sv
/*
  Stepper axis kinematics and feedback: APB registers, speed ramp,
  step generator, backlash legs, encoder decode and iterative mode.
  Assumes encoder pins are asynchronous and a driver takes step/dir.
*/
// What this block does
// - Reverse flag flips direction versus position count
// - Max speed flag overrides working speed
// - Speed limit caps at rated maximum speed
// - Speed limiting never aborts the running move
// - Winding current held at nominal current
// - RMS flag scales current, else peak
// - Backlash overshoots target then returns, in no-feedback mode only
// - Backlash sign picks approach side
// - Backlash approach uses compensation speed
// - Ramp up with accel, down with decel
// - Steps per turn relates steps to turn
// - Nine microstep modes, full to 1/256
// - Three feedback modes selectable
// - No-feedback mode only issues steps
// - Encoder mode targets counts, encoder types
// - Mediated mode iterates with encoder checks
// - Encoder counts per turn scale feedback
// - Encoder reverse flips count direction
`timescale 1ns/1ps
`default_nettype none
module skf_axis
  import skf_pkg::*;
#(
  parameter int unsigned RAMP_CYC = RAMP_CYCLES
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Motor driver
  output logic step_out,
  output logic dir_out,
  output logic [15:0] coil_current_peak,
  output logic move_busy,
  // Encoder pins
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_a_n,
  input wire logic enc_b_n
);

  // ********************
  // Functions
  // ********************
  // Microstep code, clamped to 1/256
  function automatic logic [3:0] ms_code(input logic [15:0] c);
    logic [3:0] m;
    m = c[CB_MS_LO +: 4];
    return (m > MS_MAX) ? MS_MAX : m;
  endfunction

  // Magnitude of a signed word
  function automatic logic [31:0] mag(input logic signed [32:0] x);
    logic [32:0] u;
    u = x[32] ? 33'(-x) : 33'(x);
    return u[31:0];
  endfunction

  // ********************
  // Registers
  // ********************
  logic [15:0] ctrl; // Mode and flag bits
  logic [23:0] work_speed; // Steps per second
  logic [23:0] max_speed; // Rated speed
  logic [15:0] nom_current; // Milliamps
  logic signed [15:0] backlash; // Overshoot steps
  logic [23:0] bl_speed; // Compensation speed
  logic [23:0] accel; // Speed gain per ramp tick
  logic [23:0] decel; // Speed loss per ramp tick
  logic [15:0] steps_turn; // Full steps per turn
  logic [15:0] enc_turn; // Encoder counts per turn
  logic signed [31:0] target; // Move target
  logic start_req; // Target written while idle

  // ********************
  // Motion state
  // ********************
  skf_state_t state;
  logic signed [39:0] pos_u; // Position in 1/256 steps
  logic signed [31:0] goal; // Leg end, full steps
  logic signed [31:0] enc_cnt; // Encoder count
  logic [23:0] speed; // Present step rate
  logic [32:0] phase; // Step rate accumulator
  logic step_evt; // One microstep now
  logic ramp_tick; // Ramp period pulse
  logic [$clog2(RAMP_CYC)-1:0] ramp_cnt;
  logic [15:0] win_cnt; // Counts this window
  logic [15:0] meas_cnt; // Counts last window
  logic [3:0] iter; // Mediated iteration
  logic [4:0] settle_cnt;
  logic [47:0] calc_acc; // Repeated-add divider
  logic [31:0] calc_n;
  logic diff_seen; // Auto type found complements
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [1:0] ab_prev;

  // ********************
  // Decode of settings
  // ********************
  wire [1:0] fb = ctrl[CB_FB_LO +: 2];
  wire [1:0] et = ctrl[CB_ET_LO +: 2];
  wire [3:0] ms = ms_code(ctrl);
  wire signed [31:0] pos_full = 32'(pos_u >>> 8);
  wire moving = (state == S_MOVE) || (state == S_RETURN);
  // Encoder mode measures distance in counts, others in steps
  wire signed [32:0] rem = (fb == FB_ENC) ? 33'(target) - 33'(enc_cnt)
                                          : 33'(goal) - 33'(pos_full);
  wire [31:0] rem_abs = mag(rem);
  wire at_goal = (rem == 33'sh0) && ((fb == FB_ENC) || (pos_u[7:0] == 8'h00));
  wire signed [32:0] enc_err = 33'(target) - 33'(enc_cnt);
  wire [47:0] calc_goal = 48'(mag(enc_err)) * 48'(steps_turn);
  // Measured speed: encoder rate scaled by cross-multiply, else rate
  wire [63:0] meas_lhs = 64'(meas_cnt) * 64'(RAMPS_PER_S) * 64'(steps_turn);
  wire [63:0] meas_rhs = 64'(max_speed) * 64'(enc_turn);
  wire meas_over = (fb == FB_NONE) ? (speed > max_speed) : (meas_lhs > meas_rhs);
  wire speed_over = ctrl[CB_LIMIT] && meas_over;

  // ********************
  // APB slave
  // ********************
  wire apb_setup = psel && !penable;
  wire apb_wr = psel && penable && pwrite && pready;

  // Always ready; answer data and error latched in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= 1'b1;
  end

  // Read mux and unmapped-address error
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
    else if (apb_setup)
    begin
      pslverr <= 1'b0;
      unique case (paddr)
        OFS_CTRL: prdata <= 32'(ctrl);
        OFS_WORK_SPEED: prdata <= 32'(work_speed);
        OFS_MAX_SPEED: prdata <= 32'(max_speed);
        OFS_NOM_CURRENT: prdata <= 32'(nom_current);
        OFS_BACKLASH: prdata <= 32'(backlash);
        OFS_BL_SPEED: prdata <= 32'(bl_speed);
        OFS_ACCEL: prdata <= 32'(accel);
        OFS_DECEL: prdata <= 32'(decel);
        OFS_STEPS_TURN: prdata <= 32'(steps_turn);
        OFS_ENC_TURN: prdata <= 32'(enc_turn);
        OFS_TARGET: prdata <= target;
        OFS_STATUS: prdata <= {24'h0, iter, diff_seen, speed_over, state == S_RETURN, moving};
        OFS_POSITION: prdata <= pos_full;
        OFS_ENC_COUNT: prdata <= enc_cnt;
        OFS_CUR_SPEED: prdata <= 32'(speed);
        OFS_CUR_PEAK: prdata <= 32'(coil_current_peak);
        default:
        begin
          // Unmapped: zero data with error
          prdata <= 32'h0;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

  // Settings writes; a target write starts a move only when idle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= CTRL_RST;
      work_speed <= SPEED_RST;
      max_speed <= SPEED_RST;
      nom_current <= 16'h0;
      backlash <= 16'sh0;
      bl_speed <= SPEED_RST;
      accel <= SPEED_RST;
      decel <= SPEED_RST;
      steps_turn <= STEPS_TURN_RST;
      enc_turn <= ENC_TURN_RST;
      target <= 32'sh0;
      start_req <= 1'b0;
    end
    else
    begin
      start_req <= 1'b0;
      if (apb_wr)
      begin
        unique case (paddr)
          OFS_CTRL: ctrl <= pwdata[15:0];
          OFS_WORK_SPEED: work_speed <= pwdata[23:0];
          OFS_MAX_SPEED: max_speed <= pwdata[23:0];
          OFS_NOM_CURRENT: nom_current <= pwdata[15:0];
          OFS_BACKLASH: backlash <= pwdata[15:0];
          OFS_BL_SPEED: bl_speed <= pwdata[23:0];
          OFS_ACCEL: accel <= pwdata[23:0];
          OFS_DECEL: decel <= pwdata[23:0];
          OFS_STEPS_TURN: steps_turn <= pwdata[15:0];
          OFS_ENC_TURN: enc_turn <= pwdata[15:0];
          OFS_TARGET:
          begin
            // Busy axis keeps its target
            if (state == S_IDLE)
            begin
              target <= pwdata;
              start_req <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // ********************
  // Current limit
  // ********************
  // RMS setting becomes a peak by times root two, saturated
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      coil_current_peak <= 16'h0;
    else if (ctrl[CB_RMS])
    begin
      logic [32:0] pk;
      pk = 33'(nom_current) + ((33'(nom_current) * 33'(RMS_MUL)) >> 8);
      coil_current_peak <= (pk > 33'h0ffff) ? 16'hffff : pk[15:0];
    end
    else
      coil_current_peak <= nom_current;
  end

  // ********************
  // Encoder input
  // ********************
  // Two-stage synchroniser on the four pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
    end
    else
    begin
      sync1 <= {enc_b_n, enc_a_n, enc_b, enc_a};
      sync2 <= sync1;
    end
  end

  // Autodetect: complementary pairs mean a differential encoder
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      diff_seen <= 1'b0;
    else if (et != ET_AUTO)
      diff_seen <= (et == ET_DIFF);
    else
      diff_seen <= (sync2[0] ^ sync2[2]) && (sync2[1] ^ sync2[3]);
  end

  // Differential lines must agree, else the line reads low
  wire [1:0] ab = diff_seen ? (sync2[1:0] & ~sync2[3:2]) : sync2[1:0];
  wire ab_move = ^(ab ^ ab_prev);
  wire ab_up = ab_prev[0] ^ ab[1];

  // Quadrature count, reversed on request; counts per window too
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ab_prev <= 2'h0;
      enc_cnt <= 32'sh0;
      win_cnt <= 16'h0;
      meas_cnt <= 16'h0;
    end
    else
    begin
      ab_prev <= ab;
      if (ab_move)
        enc_cnt <= (ab_up ^ ctrl[CB_ENC_REV]) ? enc_cnt + 32'sh1 : enc_cnt - 32'sh1;
      if (ramp_tick)
      begin
        meas_cnt <= win_cnt;
        win_cnt <= 16'(ab_move);
      end
      else if (ab_move && (win_cnt != 16'hffff))
        win_cnt <= win_cnt + 16'h1;
    end
  end

  // ********************
  // Speed ramp
  // ********************
  // Ramp period divider
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ramp_cnt <= '0;
      ramp_tick <= 1'b0;
    end
    else
    begin
      ramp_tick <= (ramp_cnt == ($clog2(RAMP_CYC))'(RAMP_CYC - 2));
      ramp_cnt <= ramp_tick ? '0 : ramp_cnt + 1'b1;
    end
  end

  // Target rate: return leg, override or working speed, then cap
  logic [23:0] tgt_raw;
  logic [23:0] tgt_speed;
  always_comb
  begin
    if (state == S_RETURN)
      tgt_raw = bl_speed;
    else if (ctrl[CB_MAX_SPEED])
      tgt_raw = max_speed;
    else
      tgt_raw = work_speed;
    tgt_speed = (ctrl[CB_LIMIT] && (tgt_raw > max_speed)) ? max_speed : tgt_raw;
  end

  // Brake when the stop distance at this rate reaches the remainder
  wire [79:0] brake_lhs = 80'(rem_abs) * 80'(decel) * 80'(2 * RAMPS_PER_S);
  wire brake = (decel != 24'h0) && (brake_lhs <= 80'(48'(speed) * 48'(speed)));

  // Rate update once per ramp period; limiting only slows, never stops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      speed <= 24'h0;
    else if (!moving)
      speed <= MIN_SPEED;
    else if (ramp_tick)
    begin
      if (speed_over || brake || (speed > tgt_speed))
        speed <= (25'(speed) > 25'(MIN_SPEED) + 25'(decel)) ? speed - decel : MIN_SPEED;
      else if (!ctrl[CB_ACCEL])
        speed <= tgt_speed;
      else
        speed <= (tgt_speed - speed > accel) ? speed + accel : tgt_speed;
    end
  end

  // ********************
  // Step generator
  // ********************
  wire [32:0] rate = 33'(speed) << ms;
  wire [32:0] phase_sum = phase + rate;
  wire step_on = moving && !at_goal;
  wire dir_pos = !rem[32] && !(~|rem && |pos_u[7:0]);

  // Phase accumulator makes microstep pulses at rate per second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase <= 33'h0;
      step_evt <= 1'b0;
    end
    else if (!step_on)
    begin
      phase <= 33'h0;
      step_evt <= 1'b0;
    end
    else if (phase_sum >= CLK_HZ_W)
    begin
      phase <= phase_sum - CLK_HZ_W;
      step_evt <= !step_evt;
    end
    else
    begin
      phase <= phase_sum;
      step_evt <= 1'b0;
    end
  end

  // Pins: direction pin follows count direction unless reversed
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      step_out <= 1'b0;
      dir_out <= 1'b0;
      move_busy <= 1'b0;
    end
    else
    begin
      step_out <= step_evt && step_on;
      dir_out <= dir_pos ^ ctrl[CB_REVERSE];
      move_busy <= (state != S_IDLE);
    end
  end

  // Position in 1/256 steps; each pulse moves one microstep
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pos_u <= 40'sh0;
    else if (apb_wr && (paddr == OFS_POSITION) && (state == S_IDLE))
      pos_u <= {pwdata, 8'h00};
    else if (step_evt && step_on)
    begin
      logic [39:0] inc;
      inc = 40'h1 << (4'h8 - ms);
      pos_u <= dir_pos ? pos_u + $signed(inc) : pos_u - $signed(inc);
    end
  end

  // ********************
  // Motion sequencer
  // ********************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= S_IDLE;
      goal <= 32'sh0;
      iter <= 4'h0;
      settle_cnt <= 5'h0;
      calc_acc <= 48'h0;
      calc_n <= 32'h0;
    end
    else
    begin
      unique case (state)
        S_IDLE:
        begin
          iter <= 4'h0;
          if (start_req)
          begin
            unique case (fb)
              FB_ENC: state <= S_MOVE;
              FB_MED:
              begin
                calc_acc <= 48'h0;
                calc_n <= 32'h0;
                state <= S_CALC;
              end
              default:
              begin
                // Overshoot past target by the signed count
                goal <= target + 32'(backlash);
                state <= S_MOVE;
              end
            endcase
          end
        end
        S_MOVE:
        begin
          if (at_goal)
          begin
            if (fb == FB_MED)
            begin
              settle_cnt <= 5'h0;
              state <= S_SETTLE;
            end
            else if ((fb != FB_ENC) && (backlash != 16'sh0))
            begin
              goal <= target;
              state <= S_RETURN;
            end
            else
              state <= S_IDLE;
          end
        end
        S_RETURN:
        begin
          if (at_goal)
            state <= S_IDLE;
        end
        S_CALC:
        begin
          // Steps for the encoder error by repeated adds
          if ((enc_err == 33'sh0) || (enc_turn == 16'h0))
            state <= S_IDLE;
          else if (calc_acc >= calc_goal)
          begin
            goal <= enc_err[32] ? pos_full - calc_n : pos_full + calc_n;
            state <= S_MOVE;
          end
          else
          begin
            calc_acc <= calc_acc + 48'(enc_turn);
            calc_n <= calc_n + 32'h1;
          end
        end
        S_SETTLE:
        begin
          // Let the encoder settle, then check and iterate
          if (settle_cnt == 5'(SETTLE_CYCLES - 1))
          begin
            if ((enc_err == 33'sh0) || (iter == MAX_ITER - 4'h1))
              state <= S_IDLE;
            else
            begin
              iter <= iter + 4'h1;
              calc_acc <= 48'h0;
              calc_n <= 32'h0;
              state <= S_CALC;
            end
          end
          else
            settle_cnt <= settle_cnt + 5'h1;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ### skf_pkg.sv
/*
  Constants, register map and types for the stepper kinematics block.
  Assumes a 25 MHz APB clock shared by all of the block's logic.
*/
`default_nettype none
package skf_pkg;
  // ********************
  // Clock and timing
  // ********************
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
  // Speed ramp update period, in microseconds
  localparam int unsigned RAMP_TIME_US = 1000;
  localparam int unsigned RAMP_CYCLES = RAMP_TIME_US * CLK_MHZ;
  localparam int unsigned RAMPS_PER_S = 1_000_000 / RAMP_TIME_US;
  // Encoder settle time before an iteration check, in ns
  localparam int unsigned SETTLE_TIME_NS = 640;
  localparam int unsigned SETTLE_CYCLES = (SETTLE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam logic [32:0] CLK_HZ_W = 33'h017d7840;
  localparam logic [3:0] MAX_ITER = 4'h8;
  localparam logic [23:0] MIN_SPEED = 24'h000010;
  // Root-two minus one, in 1/256 units
  localparam logic [16:0] RMS_MUL = 17'h0006a;
  // ********************
  // Register byte offsets
  // ********************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_WORK_SPEED = 8'h04;
  localparam logic [7:0] OFS_MAX_SPEED = 8'h08;
  localparam logic [7:0] OFS_NOM_CURRENT = 8'h0c;
  localparam logic [7:0] OFS_BACKLASH = 8'h10;
  localparam logic [7:0] OFS_BL_SPEED = 8'h14;
  localparam logic [7:0] OFS_ACCEL = 8'h18;
  localparam logic [7:0] OFS_DECEL = 8'h1c;
  localparam logic [7:0] OFS_STEPS_TURN = 8'h20;
  localparam logic [7:0] OFS_ENC_TURN = 8'h24;
  localparam logic [7:0] OFS_TARGET = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2c;
  localparam logic [7:0] OFS_POSITION = 8'h30;
  localparam logic [7:0] OFS_ENC_COUNT = 8'h34;
  localparam logic [7:0] OFS_CUR_SPEED = 8'h38;
  localparam logic [7:0] OFS_CUR_PEAK = 8'h3c;
  // ********************
  // Control register fields
  // ********************
  localparam int unsigned CB_REVERSE = 0;
  localparam int unsigned CB_MAX_SPEED = 1;
  localparam int unsigned CB_LIMIT = 2;
  localparam int unsigned CB_RMS = 3;
  localparam int unsigned CB_ACCEL = 4;
  localparam int unsigned CB_ENC_REV = 5;
  localparam int unsigned CB_FB_LO = 8;
  localparam int unsigned CB_ET_LO = 10;
  localparam int unsigned CB_MS_LO = 12;
  // ********************
  // Reset values and codes
  // ********************
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [23:0] SPEED_RST = 24'h0003e8;
  localparam logic [15:0] STEPS_TURN_RST = 16'h00c8;
  localparam logic [15:0] ENC_TURN_RST = 16'h0320;
  localparam logic [1:0] FB_NONE = 2'h0;
  localparam logic [1:0] FB_ENC = 2'h1;
  localparam logic [1:0] FB_MED = 2'h2;
  localparam logic [1:0] ET_SINGLE = 2'h0;
  localparam logic [1:0] ET_DIFF = 2'h1;
  localparam logic [1:0] ET_AUTO = 2'h2;
  localparam logic [3:0] MS_MAX = 4'h8;
  typedef enum logic [2:0] {S_IDLE, S_MOVE, S_RETURN, S_CALC, S_SETTLE} skf_state_t;
endpackage
`default_nettype wire

// ### skf_sva.sv
/*
  Checker for the stepper axis: APB answer timing and step pulse shape.
  Assumes it is bound to skf_axis and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module skf_sva
  import skf_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Motor driver
  input wire logic step_out,
  input wire logic move_busy
);
  // ********************
  // Shared timing
  // ********************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase of any transfer
  sequence s_access;
    psel && penable;
  endsequence
  // Target write that may start a move
  sequence s_start;
    s_access ##0 (pwrite && paddr == OFS_TARGET && !move_busy);
  endsequence
  // ********************
  // Properties
  // ********************
  property p_zero_wait;
    s_access |-> pready;
  endproperty
  property p_bad_addr;
    s_access ##0 (paddr > OFS_CUR_PEAK || paddr[1:0] != 2'h0) |-> pslverr;
  endproperty
  property p_good_addr;
    s_access ##0 (paddr <= OFS_CUR_PEAK && paddr[1:0] == 2'h0) |-> !pslverr;
  endproperty
  property p_bad_read_zero;
    s_access ##0 (!pwrite && paddr > OFS_CUR_PEAK) |-> prdata == 32'h0;
  endproperty
  // Answer holds through the cycle after the access
  property p_answer_holds;
    s_access |=> $stable(prdata) && $stable(pslverr);
  endproperty
  property p_step_pulse;
    step_out |=> !step_out;
  endproperty
  property p_step_busy;
    step_out |-> move_busy;
  endproperty
  property p_move_start;
    s_start |-> ##[1:3] move_busy;
  endproperty
  a_zero_wait: assert property (p_zero_wait)
    else $error("access without ready");
  a_bad_addr: assert property (p_bad_addr)
    else $error("unmapped access without error");
  a_good_addr: assert property (p_good_addr)
    else $error("mapped access flagged as error");
  a_bad_read_zero: assert property (p_bad_read_zero)
    else $error("unmapped read not zero");
  a_answer_holds: assert property (p_answer_holds)
    else $error("read answer changed after access");
  a_step_pulse: assert property (p_step_pulse)
    else $error("step pulse longer than one cycle");
  a_step_busy: assert property (p_step_busy)
    else $error("step issued while idle");
  a_move_start: assert property (p_move_start)
    else $error("target write did not start a move");
endmodule
`default_nettype wire

// ### skf_enc_model.sv
/*
  Encoder partner: one quadrature transition per step pulse.
  Assumes step_out and dir_out come straight from the axis.
*/
`timescale 1ns/1ps
`default_nettype none
module skf_enc_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Motor driver side
  input wire logic step_out,
  input wire logic dir_out,
  // Encoder pins
  output logic enc_a,
  output logic enc_b,
  output logic enc_a_n,
  output logic enc_b_n
);
  // Shaft phase, gray-coded onto the pins
  logic [1:0] phase;
  // Follows the shaft; pins never hold a stale level across a step
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      phase <= 2'h0;
    else if (step_out)
      phase <= dir_out ? phase + 2'h1 : phase - 2'h1;
  end
  assign enc_a = phase[1];
  assign enc_b = phase[1] ^ phase[0];
  // Complement pair, so a differential receiver sees a clean pair
  assign enc_a_n = !enc_a;
  assign enc_b_n = !enc_b;
endmodule
`default_nettype wire

// ### stepper_kinematics_feedback_bench.sv
/*
  Self-checking bench for skf_axis with the encoder partner.
  Assumes a short ramp tick so moves finish quickly.
*/
`timescale 1ns/1ps
`default_nettype none
module stepper_kinematics_feedback_bench;
  import skf_pkg::*;
  // Design ports
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, step_out, dir_out, move_busy;
  logic [15:0] coil_current_peak;
  logic enc_a, enc_b, enc_a_n, enc_b_n;
  // Bookkeeping
  int miscompares = 0;
  int check_count = 0;
  int up, dn, cyc;
  logic [31:0] rd;
  logic er;
  logic [31:0] pos = 32'h0;
  typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] x; logic e;} skf_row_t;
  // Reset values, setup writes with readback, refused accesses
  skf_row_t rows[$] = '{
    '{8'h00, 1'b0, 0, 32'h0, 1'b0}, '{8'h04, 1'b0, 0, 32'h3e8, 1'b0},
    '{8'h08, 1'b0, 0, 32'h3e8, 1'b0}, '{8'h0c, 1'b0, 0, 32'h0, 1'b0},
    '{8'h10, 1'b0, 0, 32'h0, 1'b0}, '{8'h14, 1'b0, 0, 32'h3e8, 1'b0},
    '{8'h18, 1'b0, 0, 32'h3e8, 1'b0}, '{8'h1c, 1'b0, 0, 32'h3e8, 1'b0},
    '{8'h20, 1'b0, 0, 32'hc8, 1'b0}, '{8'h24, 1'b0, 0, 32'h320, 1'b0},
    '{8'h2c, 1'b1, 32'hff, 0, 1'b0}, '{8'h2c, 1'b0, 0, 32'h0, 1'b0},
    '{8'h40, 1'b1, 32'h5, 0, 1'b1}, '{8'h40, 1'b0, 0, 32'h0, 1'b1},
    '{8'h04, 1'b1, 32'h4e20, 0, 1'b0}, '{8'h08, 1'b1, 32'h4e20, 0, 1'b0},
    '{8'h14, 1'b1, 32'h4e20, 0, 1'b0}, '{8'h18, 1'b1, 32'hffffff, 0, 1'b0},
    '{8'h1c, 1'b1, 32'hffffff, 0, 1'b0}, '{8'h0c, 1'b1, 32'h3e8, 0, 1'b0},
    '{8'h20, 1'b1, 32'h190, 0, 1'b0}, '{8'h20, 1'b0, 0, 32'h190, 1'b0},
    '{8'h18, 1'b0, 0, 32'hffffff, 1'b0}, '{8'h14, 1'b0, 0, 32'h4e20, 1'b0}};
  // 25 MHz clock
  always #20 pclk = ~pclk;
  // ********************
  // Design and partner
  // ********************
  skf_axis #(.RAMP_CYC(50)) skf_axis_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .step_out(step_out), .dir_out(dir_out),
    .coil_current_peak(coil_current_peak), .move_busy(move_busy), .enc_a(enc_a),
    .enc_b(enc_b), .enc_a_n(enc_a_n), .enc_b_n(enc_b_n));
  skf_enc_model skf_enc_model_inst (.pclk(pclk), .presetn(presetn), .step_out(step_out),
    .dir_out(dir_out), .enc_a(enc_a), .enc_b(enc_b), .enc_a_n(enc_a_n), .enc_b_n(enc_b_n));
  // ********************
  // Tasks
  // ********************
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", n, exp, seen);
    end
  endtask
  // One APB transfer; waits on pready, the watchdog ends a hang
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Write a target, count pulses by direction until idle
  task automatic mv(input logic [31:0] t);
    up = 0;
    dn = 0;
    cyc = 0;
    apb(OFS_TARGET, 1'b1, t);
    while ((cyc < 4 || move_busy === 1'b1) && cyc < 20000)
    begin
      @(posedge pclk);
      cyc++;
      if (step_out === 1'b1 && dir_out === 1'b1)
        up++;
      if (step_out === 1'b1 && dir_out === 1'b0)
        dn++;
    end
    chk("move end", {31'h0, move_busy}, 32'h0);
  endtask
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ********************
  // Main sequence
  // ********************
  initial
  begin
    repeat (20) @(posedge pclk);
    chk("reset pready", {31'h0, pready}, 32'h0);
    chk("reset current", {16'h0, coil_current_peak}, 32'h0);
    presetn <= 1'b1;
    foreach (rows[i])
    begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      chk("pslverr", {31'h0, er}, {31'h0, rows[i].e});
      if (!rows[i].w)
        chk("prdata", rd, rows[i].x);
    end
    repeat (3) @(posedge pclk);
    chk("peak current", {16'h0, coil_current_peak}, 32'h3e8);
    apb(OFS_CTRL, 1'b1, 32'h8);
    repeat (3) @(posedge pclk);
    chk("rms current", {16'h0, coil_current_peak}, 32'h3e8 + 32'h3e8 * RMS_MUL / 256);
    // Every microstep code, pulses per full step double each time
    for (int m = 0; m <= 8; m++)
    begin
      apb(OFS_CTRL, 1'b1, 32'(m) << 12);
      pos += 2;
      mv(pos);
      chk("usteps", up, 32'd2 << m);
      chk("usteps back", dn, 0);
    end
    apb(OFS_POSITION, 1'b0, 0);
    chk("position", rd, pos);
    // Reversed direction still counts position up
    apb(OFS_CTRL, 1'b1, 32'h1);
    pos += 2;
    mv(pos);
    chk("reverse dir", dn, 2);
    chk("reverse other", up, 0);
    // Backlash from the right, then from the left
    apb(OFS_CTRL, 1'b1, 32'h0);
    apb(OFS_BACKLASH, 1'b1, 32'h3);
    pos += 2;
    mv(pos);
    chk("overshoot", up, 5);
    chk("return", dn, 3);
    apb(OFS_BACKLASH, 1'b1, 32'hfffd);
    pos += 2;
    mv(pos);
    chk("left first", dn, 1);
    chk("left return", up, 3);
    apb(OFS_BACKLASH, 1'b1, 32'h0);
    // A target written mid-move is ignored
    pos += 4;
    apb(OFS_TARGET, 1'b1, pos);
    repeat (3) @(posedge pclk);
    mv(32'h0);
    apb(OFS_POSITION, 1'b0, 0);
    chk("busy target", rd, pos);
    // Speed cap slows the move without stopping it
    apb(OFS_MAX_SPEED, 1'b1, 32'h2710);
    apb(OFS_CTRL, 1'b1, 32'h4);
    pos += 4;
    mv(pos);
    chk("limited steps", up, 4);
    chk("limited slow", {31'h0, cyc > 7000}, 32'h1);
    // Max speed flag overrides a crawling working speed
    apb(OFS_WORK_SPEED, 1'b1, 32'h10);
    apb(OFS_MAX_SPEED, 1'b1, 32'h4e20);
    apb(OFS_CTRL, 1'b1, 32'h2);
    pos += 2;
    mv(pos);
    chk("max speed", up, 2);
    // Targets in encoder counts
    apb(OFS_CTRL, 1'b1, 32'h102);
    apb(OFS_ENC_COUNT, 1'b0, 0);
    mv(rd + 3);
    chk("enc steps", up, 3);
    complete_run();
  end
  // Watchdog: all moves fit well inside this span
  initial
  begin
    repeat (100000) @(posedge pclk);
    miscompares++;
    complete_run();
  end
endmodule
bind skf_axis skf_sva skf_sva_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .step_out(step_out), .move_busy(move_busy));
`default_nettype wire
